// >>> rtl/pmwd_decoder.sv
// Address map decoder with paged program, data and extra windows
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - The program window is fixed at 0x8000 to 0xbfff, 16 Kbytes.
// - There are program, data and extra windows; data and extra have settable base and size.
// - Each window has its own 8-bit page select, one page visible at a time out of 256, out of 128 when the data window is 32 Kbytes.
// - Data and extra pages change through plain bus writes to their page selects.
// - The program page is loaded by paged call and return as well as by a register write.
// - Addresses 0xc000 to 0xffff are never translated.
// - Overlaps resolve by precedence: debug registers, registers, debug ROM, vectors, RAM, EEPROM, flash, windows.
// - Registers, vectors and on-chip memory win whatever the page selects hold.
// - While background debug is active a debug ROM sits at 0xff20 to 0xffff.
// - While background debug is active debug registers sit at 0xff00 to 0xff06.
// - Outside background debug neither debug ROM nor debug registers are in the map.
// - On-chip resources reset to default bases which control registers can move.
// - A program window access puts the program page on lines 21 to 14, low 14 bits within the page.
// - An access outside every enabled window drives lines 21 to 16 high.
// - Window enables are clear after reset, so no translation until software enables them.
module pmwd_decoder
  import pmwd_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              access_valid,
  input  wire logic              access_write,
  input  wire logic [ADDR_W-1:0] access_addr,
  input  wire logic [7:0]        access_wdata,
  input  wire logic              call_page_load,
  input  wire logic [PAGE_W-1:0] call_page_value,
  input  wire logic              background_debug_active,
  output pmwd_pkg::pmwd_target_t target_q,
  output logic                   target_valid_q,
  output logic [EXT_W-1:0]       ext_addr_q,
  output logic [ADDR_W-1:0]      local_addr_q,
  output logic [7:0]             reg_rdata_q,
  output logic [PAGE_W-1:0]      program_page_select,
  output logic [PAGE_W-1:0]      data_page_select,
  output logic [PAGE_W-1:0]      extra_page_select
);
  import pmwd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] first,
                                    input logic [ADDR_W-1:0] last);
    in_range = (a >= first) && (a <= last);
  endfunction : in_range

  function automatic logic [3:0] size_log2(input logic [3:0] min_log2,
                                           input logic [1:0] code);
    size_log2 = min_log2 + {2'b00, code};
  endfunction : size_log2

  function automatic logic [EXT_W-1:0] unpaged_ext(input logic [ADDR_W-1:0] a);
    unpaged_ext = {ADDR_HI_IDLE, a};
  endfunction : unpaged_ext

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [2:0]        win_enable_q;
  logic [7:0]        data_base_q;
  logic [1:0]        data_size_q;
  logic [7:0]        extra_base_q;
  logic [1:0]        extra_size_q;
  logic [5:0]        reg_base_q;
  logic [5:0]        ram_base_q;
  logic [3:0]        ee_base_q;
  logic [1:0]        flash_base_q;
  logic              reg_wr_en;

  pmwd_map_regs u_map_regs (
    .clock        (clock),
    .reset_n      (reset_n),
    .wr_en        (reg_wr_en),
    .wr_ofs       (access_addr[OFS_W-1:0]),
    .wr_data      (access_wdata),
    .call_load    (call_page_load),
    .call_page    (call_page_value),
    .prog_page_q  (program_page_select),
    .data_page_q  (data_page_select),
    .extra_page_q (extra_page_select),
    .win_enable_q (win_enable_q),
    .data_base_q  (data_base_q),
    .data_size_q  (data_size_q),
    .extra_base_q (extra_base_q),
    .extra_size_q (extra_size_q),
    .reg_base_q   (reg_base_q),
    .ram_base_q   (ram_base_q),
    .ee_base_q    (ee_base_q),
    .flash_base_q (flash_base_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Overlay windows

  logic             prog_hit;
  logic             data_hit;
  logic             extra_hit;
  logic [EXT_W-1:0] prog_ext;
  logic [EXT_W-1:0] data_ext;
  logic [EXT_W-1:0] extra_ext;
  logic [3:0]       data_log2;
  logic [3:0]       extra_log2;

  always_comb begin
    data_log2  = size_log2(DATA_LOG2_MIN, data_size_q);
    extra_log2 = size_log2(EXTRA_LOG2_MIN, extra_size_q);
  end

  pmwd_window u_prog_win (
    .addr      (access_addr),
    .enable    (win_enable_q[EN_PROG]),
    .base      (PROG_WIN_BASE),
    .log2_size (PROG_WIN_LOG2),
    .page      (program_page_select),
    .hit       (prog_hit),
    .ext_addr  (prog_ext)
  );

  pmwd_window u_data_win (
    .addr      (access_addr),
    .enable    (win_enable_q[EN_DATA]),
    .base      (data_base_q),
    .log2_size (data_log2),
    .page      (data_page_select),
    .hit       (data_hit),
    .ext_addr  (data_ext)
  );

  pmwd_window u_extra_win (
    .addr      (access_addr),
    .enable    (win_enable_q[EN_EXTRA]),
    .base      (extra_base_q),
    .log2_size (extra_log2),
    .page      (extra_page_select),
    .hit       (extra_hit),
    .ext_addr  (extra_ext)
  );

  logic             win_any;
  pmwd_target_t     win_target;
  logic [EXT_W-1:0] win_ext;

  // Windows rank among themselves first
  always_comb begin
    win_any    = prog_hit || data_hit || extra_hit;
    win_target = PMWD_TGT_EXTERNAL;
    win_ext    = unpaged_ext(access_addr);
    if (prog_hit) begin
      win_target = PMWD_TGT_PROG_WIN;
      win_ext    = prog_ext;
    end else if (data_hit) begin
      win_target = PMWD_TGT_DATA_WIN;
      win_ext    = data_ext;
    end else if (extra_hit) begin
      win_target = PMWD_TGT_EXTRA_WIN;
      win_ext    = extra_ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Resource hits

  logic dbg_reg_hit;
  logic dbg_rom_hit;
  logic reg_hit;
  logic vec_hit;
  logic ram_hit;
  logic ee_hit;
  logic flash_hit;

  always_comb begin
    dbg_reg_hit = background_debug_active && in_range(access_addr, DBG_REG_FIRST, DBG_REG_LAST);
    dbg_rom_hit = background_debug_active && in_range(access_addr, DBG_ROM_FIRST, DBG_ROM_LAST);
    reg_hit     = (access_addr[15:10] == reg_base_q);
    vec_hit     = (access_addr >= VEC_FIRST);
    ram_hit     = (access_addr[15:10] == ram_base_q);
    ee_hit      = (access_addr[15:12] == ee_base_q);
    flash_hit   = (access_addr[15:14] == flash_base_q);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Precedence decode

  pmwd_target_t     target_sel;
  logic [EXT_W-1:0] ext_sel;

  always_comb begin
    target_sel = PMWD_TGT_EXTERNAL;
    ext_sel    = unpaged_ext(access_addr);
    if (dbg_reg_hit) begin
      target_sel = PMWD_TGT_DEBUG_REG;
    end else if (reg_hit) begin
      target_sel = PMWD_TGT_REGS;
    end else if (dbg_rom_hit) begin
      target_sel = PMWD_TGT_DEBUG_ROM;
    end else if (vec_hit) begin
      target_sel = PMWD_TGT_VECTORS;
    end else if (ram_hit) begin
      target_sel = PMWD_TGT_RAM;
    end else if (ee_hit) begin
      target_sel = PMWD_TGT_EEPROM;
    end else if (flash_hit) begin
      target_sel = PMWD_TGT_FLASH;
    end else if (win_any) begin
      target_sel = win_target;
      ext_sel    = win_ext;
    end
  end

  logic reg_rd_en;

  // Register block answers only when it wins the decode
  always_comb begin
    reg_wr_en = access_valid && access_write && (target_sel == PMWD_TGT_REGS);
    reg_rd_en = access_valid && !access_write && (target_sel == PMWD_TGT_REGS);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux

  logic [7:0] reg_rdata_sel;

  always_comb begin
    case (access_addr[OFS_W-1:0])
      OFS_PROG_PAGE:  reg_rdata_sel = program_page_select;
      OFS_DATA_PAGE:  reg_rdata_sel = data_page_select;
      OFS_EXTRA_PAGE: reg_rdata_sel = extra_page_select;
      OFS_WIN_ENABLE: reg_rdata_sel = {5'b00000, win_enable_q};
      OFS_DATA_BASE:  reg_rdata_sel = data_base_q;
      OFS_DATA_SIZE:  reg_rdata_sel = {6'b000000, data_size_q};
      OFS_EXTRA_BASE: reg_rdata_sel = extra_base_q;
      OFS_EXTRA_SIZE: reg_rdata_sel = {6'b000000, extra_size_q};
      OFS_REG_BASE:   reg_rdata_sel = {reg_base_q, 2'b00};
      OFS_RAM_BASE:   reg_rdata_sel = {ram_base_q, 2'b00};
      OFS_EE_BASE:    reg_rdata_sel = {ee_base_q, 4'h0};
      OFS_FLASH_BASE: reg_rdata_sel = {flash_base_q, 6'b000000};
      default:        reg_rdata_sel = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers

  pmwd_target_t      target_d;
  logic              target_valid_d;
  logic [EXT_W-1:0]  ext_addr_d;
  logic [ADDR_W-1:0] local_addr_d;
  logic [7:0]        reg_rdata_d;

  always_comb begin
    target_d       = target_q;
    target_valid_d = access_valid;
    ext_addr_d     = ext_addr_q;
    local_addr_d   = local_addr_q;
    reg_rdata_d    = reg_rdata_q;
    if (access_valid) begin
      target_d     = target_sel;
      ext_addr_d   = ext_sel;
      local_addr_d = access_addr;
      if (reg_rd_en) begin
        reg_rdata_d = reg_rdata_sel;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      target_q       <= PMWD_TGT_EXTERNAL;
      target_valid_q <= 1'b0;
      ext_addr_q     <= {ADDR_HI_IDLE, 16'h0000};
      local_addr_q   <= 16'h0000;
      reg_rdata_q    <= 8'h00;
    end else begin
      target_q       <= target_d;
      target_valid_q <= target_valid_d;
      ext_addr_q     <= ext_addr_d;
      local_addr_q   <= local_addr_d;
      reg_rdata_q    <= reg_rdata_d;
    end
  end

endmodule : pmwd_decoder

// >>> rtl/pmwd_pkg.sv
// Constants and types shared by the paged memory window decoder
package pmwd_pkg;

  localparam int ADDR_W     = 16;
  localparam int EXT_W      = 22;
  localparam int PAGE_W     = 8;
  localparam int OFS_W      = 10;

  // Fixed map points
  localparam logic [15:0] PROG_WIN_FIRST = 16'h8000;
  localparam logic [15:0] PROG_WIN_LAST  = 16'hbfff;
  localparam logic [15:0] UNPAGED_FIRST  = 16'hc000;
  localparam logic [15:0] DBG_REG_FIRST  = 16'hff00;
  localparam logic [15:0] DBG_REG_LAST   = 16'hff06;
  localparam logic [15:0] DBG_ROM_FIRST  = 16'hff20;
  localparam logic [15:0] DBG_ROM_LAST   = 16'hffff;
  localparam logic [15:0] VEC_FIRST      = 16'hff80;

  // Program window shape and minimum data and extra window sizes
  localparam logic [7:0] PROG_WIN_BASE   = 8'h80;
  localparam logic [3:0] PROG_WIN_LOG2   = 4'd14;
  localparam logic [3:0] DATA_LOG2_MIN   = 4'd12;
  localparam logic [3:0] EXTRA_LOG2_MIN  = 4'd10;

  // Lines above the 16-bit map when nothing translates
  localparam logic [5:0] ADDR_HI_IDLE    = 6'h3f;

  // Offsets inside the control register block (1 Kbyte)
  localparam logic [9:0] OFS_PROG_PAGE   = 10'h030;
  localparam logic [9:0] OFS_DATA_PAGE   = 10'h031;
  localparam logic [9:0] OFS_EXTRA_PAGE  = 10'h032;
  localparam logic [9:0] OFS_WIN_ENABLE  = 10'h033;
  localparam logic [9:0] OFS_DATA_BASE   = 10'h034;
  localparam logic [9:0] OFS_DATA_SIZE   = 10'h035;
  localparam logic [9:0] OFS_EXTRA_BASE  = 10'h036;
  localparam logic [9:0] OFS_EXTRA_SIZE  = 10'h037;
  localparam logic [9:0] OFS_REG_BASE    = 10'h038;
  localparam logic [9:0] OFS_RAM_BASE    = 10'h039;
  localparam logic [9:0] OFS_EE_BASE     = 10'h03a;
  localparam logic [9:0] OFS_FLASH_BASE  = 10'h03b;

  // Enable bit positions
  localparam int EN_PROG  = 0;
  localparam int EN_DATA  = 1;
  localparam int EN_EXTRA = 2;

  // Reset values
  localparam logic [7:0] PAGE_RST        = 8'h00;
  localparam logic [2:0] WIN_ENABLE_RST  = 3'b000;
  localparam logic [7:0] DATA_BASE_RST   = 8'h70;
  localparam logic [1:0] DATA_SIZE_RST   = 2'd0;
  localparam logic [7:0] EXTRA_BASE_RST  = 8'h04;
  localparam logic [1:0] EXTRA_SIZE_RST  = 2'd0;
  localparam logic [5:0] REG_BASE_RST    = 6'h00;
  localparam logic [5:0] RAM_BASE_RST    = 6'h02;
  localparam logic [3:0] EE_BASE_RST     = 4'h1;
  localparam logic [1:0] FLASH_BASE_RST  = 2'h1;

  typedef enum logic [3:0] {
    PMWD_TGT_EXTERNAL  = 4'h0,
    PMWD_TGT_REGS      = 4'h1,
    PMWD_TGT_DEBUG_REG = 4'h2,
    PMWD_TGT_VECTORS   = 4'h3,
    PMWD_TGT_DEBUG_ROM = 4'h4,
    PMWD_TGT_RAM       = 4'h5,
    PMWD_TGT_EEPROM    = 4'h6,
    PMWD_TGT_FLASH     = 4'h7,
    PMWD_TGT_PROG_WIN  = 4'h8,
    PMWD_TGT_DATA_WIN  = 4'h9,
    PMWD_TGT_EXTRA_WIN = 4'ha
  } pmwd_target_t;

endpackage : pmwd_pkg

// >>> rtl/pmwd_window.sv
// One overlay window: hit detection and page translation
module pmwd_window
  import pmwd_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              enable,
  input  wire logic [7:0]        base,
  input  wire logic [3:0]        log2_size,
  input  wire logic [PAGE_W-1:0] page,
  output logic                   hit,
  output logic [EXT_W-1:0]       ext_addr
);
  import pmwd_pkg::*;

  logic [ADDR_W-1:0] mask;

  always_comb begin
    mask     = 16'hffff << log2_size;
    hit      = enable && ((addr & mask) == ({base, 8'h00} & mask)) && (addr < UNPAGED_FIRST);
    ext_addr = (EXT_W'(page) << log2_size) | EXT_W'(addr & ~mask);
  end

endmodule : pmwd_window

// >>> rtl/pmwd_map_regs.sv
// Page select, window and base relocation registers
module pmwd_map_regs
  import pmwd_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              wr_en,
  input  wire logic [OFS_W-1:0]  wr_ofs,
  input  wire logic [7:0]        wr_data,
  input  wire logic              call_load,
  input  wire logic [PAGE_W-1:0] call_page,
  output logic [PAGE_W-1:0]      prog_page_q,
  output logic [PAGE_W-1:0]      data_page_q,
  output logic [PAGE_W-1:0]      extra_page_q,
  output logic [2:0]             win_enable_q,
  output logic [7:0]             data_base_q,
  output logic [1:0]             data_size_q,
  output logic [7:0]             extra_base_q,
  output logic [1:0]             extra_size_q,
  output logic [5:0]             reg_base_q,
  output logic [5:0]             ram_base_q,
  output logic [3:0]             ee_base_q,
  output logic [1:0]             flash_base_q
);
  import pmwd_pkg::*;

  logic [PAGE_W-1:0] prog_page_d;
  logic [PAGE_W-1:0] data_page_d;
  logic [PAGE_W-1:0] extra_page_d;
  logic [2:0]        win_enable_d;
  logic [7:0]        data_base_d;
  logic [1:0]        data_size_d;
  logic [7:0]        extra_base_d;
  logic [1:0]        extra_size_d;
  logic [5:0]        reg_base_d;
  logic [5:0]        ram_base_d;
  logic [3:0]        ee_base_d;
  logic [1:0]        flash_base_d;

  always_comb begin
    prog_page_d  = prog_page_q;
    data_page_d  = data_page_q;
    extra_page_d = extra_page_q;
    win_enable_d = win_enable_q;
    data_base_d  = data_base_q;
    data_size_d  = data_size_q;
    extra_base_d = extra_base_q;
    extra_size_d = extra_size_q;
    reg_base_d   = reg_base_q;
    ram_base_d   = ram_base_q;
    ee_base_d    = ee_base_q;
    flash_base_d = flash_base_q;
    if (wr_en) begin
      case (wr_ofs)
        OFS_PROG_PAGE:  prog_page_d  = wr_data;
        OFS_DATA_PAGE:  data_page_d  = wr_data;
        OFS_EXTRA_PAGE: extra_page_d = wr_data;
        OFS_WIN_ENABLE: win_enable_d = wr_data[2:0];
        OFS_DATA_BASE:  data_base_d  = wr_data;
        OFS_DATA_SIZE:  data_size_d  = wr_data[1:0];
        OFS_EXTRA_BASE: extra_base_d = wr_data;
        OFS_EXTRA_SIZE: extra_size_d = wr_data[1:0];
        OFS_REG_BASE:   reg_base_d   = wr_data[7:2];
        OFS_RAM_BASE:   ram_base_d   = wr_data[7:2];
        OFS_EE_BASE:    ee_base_d    = wr_data[7:4];
        OFS_FLASH_BASE: flash_base_d = wr_data[7:6];
        default: begin
        end
      endcase
    end
    // Paged call and return load the program page over a bus write
    if (call_load) begin
      prog_page_d = call_page;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prog_page_q  <= PAGE_RST;
      data_page_q  <= PAGE_RST;
      extra_page_q <= PAGE_RST;
      win_enable_q <= WIN_ENABLE_RST;
      data_base_q  <= DATA_BASE_RST;
      data_size_q  <= DATA_SIZE_RST;
      extra_base_q <= EXTRA_BASE_RST;
      extra_size_q <= EXTRA_SIZE_RST;
      reg_base_q   <= REG_BASE_RST;
      ram_base_q   <= RAM_BASE_RST;
      ee_base_q    <= EE_BASE_RST;
      flash_base_q <= FLASH_BASE_RST;
    end else begin
      prog_page_q  <= prog_page_d;
      data_page_q  <= data_page_d;
      extra_page_q <= extra_page_d;
      win_enable_q <= win_enable_d;
      data_base_q  <= data_base_d;
      data_size_q  <= data_size_d;
      extra_base_q <= extra_base_d;
      extra_size_q <= extra_size_d;
      reg_base_q   <= reg_base_d;
      ram_base_q   <= ram_base_d;
      ee_base_q    <= ee_base_d;
      flash_base_q <= flash_base_d;
    end
  end

endmodule : pmwd_map_regs

// >>> testbench/pmwd_decoder_chk.sv
// Port assertions for the paged memory window decoder
module pmwd_decoder_chk (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic                   access_valid,
  input wire logic [15:0]            access_addr,
  input wire logic                   call_page_load,
  input wire logic [7:0]             call_page_value,
  input wire logic                   background_debug_active,
  input wire pmwd_pkg::pmwd_target_t target_q,
  input wire logic                   target_valid_q,
  input wire logic [21:0]            ext_addr_q,
  input wire logic [15:0]            local_addr_q,
  input wire logic [7:0]             program_page_select,
  input wire logic [7:0]             data_page_select,
  input wire logic [7:0]             extra_page_select
);
  import pmwd_pkg::*;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  valid_follows_a: assert property (access_valid |=> target_valid_q)
    else $error("no result after access");
  idle_quiet_a: assert property (!access_valid |=> !target_valid_q)
    else $error("result without access");
  prog_range_a: assert property (target_valid_q && target_q == PMWD_TGT_PROG_WIN |->
    local_addr_q inside {[16'h8000:16'hbfff]}) else $error("program window hit outside its range");
  prog_xlate_a: assert property (access_valid ##1 (target_valid_q && target_q == PMWD_TGT_PROG_WIN) |->
    ext_addr_q == {$past(program_page_select), local_addr_q[13:0]}) else $error("program translation wrong");
  unpaged_top_a: assert property (target_valid_q && local_addr_q[15:14] == 2'b11 |->
    ext_addr_q == {6'h3f, local_addr_q}) else $error("top region translated");
  idle_lines_a: assert property (target_valid_q && !(target_q inside {PMWD_TGT_PROG_WIN, PMWD_TGT_DATA_WIN,
    PMWD_TGT_EXTRA_WIN}) |-> ext_addr_q[21:16] == 6'h3f) else $error("high lines not idle");
  dbg_regs_a: assert property (access_valid && background_debug_active && access_addr inside
    {[16'hff00:16'hff06]} |=> target_q == PMWD_TGT_DEBUG_REG) else $error("debug registers missed");
  dbg_rom_a: assert property (target_valid_q && target_q == PMWD_TGT_DEBUG_ROM |->
    $past(background_debug_active) && local_addr_q >= 16'hff20) else $error("debug rom misplaced");
  dbg_gone_a: assert property (access_valid && !background_debug_active |=>
    !(target_q inside {PMWD_TGT_DEBUG_REG, PMWD_TGT_DEBUG_ROM})) else $error("debug resource in normal map");
  call_load_a: assert property (call_page_load |=> program_page_select == $past(call_page_value))
    else $error("paged call did not load page");
  page_hold_a: assert property (!access_valid |=> $stable(data_page_select) && $stable(extra_page_select))
    else $error("page changed without a write");
  page_reset_a: assert property ($rose(reset_n) |->
    {program_page_select, data_page_select, extra_page_select} == 24'h0) else $error("pages not zero at reset");
endmodule : pmwd_decoder_chk

bind pmwd_decoder pmwd_decoder_chk pmwd_decoder_chk_i (
  .clock(clock), .reset_n(reset_n), .access_valid(access_valid), .access_addr(access_addr),
  .call_page_load(call_page_load), .call_page_value(call_page_value),
  .background_debug_active(background_debug_active), .target_q(target_q), .target_valid_q(target_valid_q),
  .ext_addr_q(ext_addr_q), .local_addr_q(local_addr_q), .program_page_select(program_page_select),
  .data_page_select(data_page_select), .extra_page_select(extra_page_select)
);

// >>> testbench/pmwd_core_model.sv
// Processor core model driving the decoder access port
module pmwd_core_model (
  input  wire logic        clock,
  output logic             access_valid,
  output logic             access_write,
  output logic [15:0]      access_addr,
  output logic [7:0]       access_wdata,
  output logic             call_page_load,
  output logic [7:0]       call_page_value
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    access_valid = 1'b0;
    access_write = 1'b0;
    access_addr = 16'h5a5a;
    access_wdata = 8'ha5;
    call_page_load = 1'b0;
    call_page_value = 8'h3c;
  end

  // One access, optionally late, with an optional paged call beside it
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, input logic cl,
                        input logic [7:0] cp, input int gap);
    repeat (gap) @(negedge clock);
    @(negedge clock);
    access_valid = 1'b1;
    access_write = w;
    access_addr = a;
    access_wdata = d;
    call_page_load = cl;
    call_page_value = cp;
    @(negedge clock);
    access_valid = 1'b0;
    access_write = 1'b0;
    access_addr = ~a;
    access_wdata = ~d;
    call_page_load = 1'b0;
    call_page_value = ~cp;
  endtask : access
endmodule : pmwd_core_model

// >>> testbench/pmwd_decoder_tb.sv
// Self-checking bench for the paged memory window decoder
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module pmwd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmwd_pkg::*;

  logic         clock, reset_n, background_debug_active;
  logic         access_valid, access_write, call_page_load;
  logic [15:0]  access_addr, local_addr_q;
  logic [7:0]   access_wdata, call_page_value, reg_rdata_q;
  logic [7:0]   program_page_select, data_page_select, extra_page_select;
  pmwd_target_t target_q;
  logic         target_valid_q;
  logic [21:0]  ext_addr_q;
  int           n_errors = 0;
  int           num_checks = 0;
  int           pp, dp, ep, en, rb, dbg, ds, xs;
  int           db = DATA_BASE_RST, xb = EXTRA_BASE_RST;
  logic [31:0]  rnd = 32'd88892;
  logic [15:0]  addrs [20] = '{16'h8000, 16'h9000, 16'hbfff, 16'hc000, 16'h0400, 16'h07ff, 16'h7000,
    16'h0800, 16'h1000, 16'h4000, 16'h0030, 16'h0031, 16'h0032, 16'h0033, 16'h003c, 16'hff80, 16'hff00,
    16'hff06, 16'hff07, 16'hff20};

  pmwd_core_model pmwd_core_model_i (.clock(clock), .access_valid(access_valid), .access_write(access_write),
    .access_addr(access_addr), .access_wdata(access_wdata), .call_page_load(call_page_load),
    .call_page_value(call_page_value));
  pmwd_decoder pmwd_decoder_i (.clock(clock), .reset_n(reset_n), .access_valid(access_valid),
    .access_write(access_write), .access_addr(access_addr), .access_wdata(access_wdata),
    .call_page_load(call_page_load), .call_page_value(call_page_value),
    .background_debug_active(background_debug_active), .target_q(target_q), .target_valid_q(target_valid_q),
    .ext_addr_q(ext_addr_q), .local_addr_q(local_addr_q), .reg_rdata_q(reg_rdata_q),
    .program_page_select(program_page_select), .data_page_select(data_page_select),
    .extra_page_select(extra_page_select));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int tgt(input logic [15:0] a);
    if (dbg != 0 && a >= 16'hff00 && a <= 16'hff06) return 2;
    if (a[15:10] == rb) return 1;
    if (dbg != 0 && a >= 16'hff20) return 4;
    if (a >= 16'hff80) return 3;
    if (a[15:10] == 6'h02) return 5;
    if (a[15:12] == 4'h1) return 6;
    if (a[15:14] == 2'h1) return 7;
    if (en[0] && a[15:14] == 2'h2) return 8;
    if (en[1] && a < 16'hc000 && (a >> (12 + ds)) == (db << 8) >> (12 + ds)) return 9;
    if (en[2] && a < 16'hc000 && (a >> (10 + xs)) == (xb << 8) >> (10 + xs)) return 10;
    return 0;
  endfunction : tgt

  function automatic logic [21:0] ext(input logic [15:0] a, input int t);
    case (t)
      8: return {pp[7:0], a[13:0]};
      9: return 22'(dp << (12 + ds)) | 22'(a % (1 << (12 + ds)));
      10: return 22'(ep << (10 + xs)) | 22'(a % (1 << (10 + xs)));
      default: return {6'h3f, a};
    endcase
  endfunction : ext

  function automatic logic [7:0] rreg(input logic [9:0] o);
    case (o)
      10'h030: return pp[7:0];
      10'h031: return dp[7:0];
      10'h032: return ep[7:0];
      10'h033: return en[7:0];
      10'h034: return db[7:0];
      10'h035: return ds[7:0];
      10'h036: return xb[7:0];
      10'h037: return xs[7:0];
      10'h038: return 8'(rb << 2);
      10'h039: return {RAM_BASE_RST, 2'b00};
      10'h03a: return {EE_BASE_RST, 4'h0};
      10'h03b: return {FLASH_BASE_RST, 6'h00};
      default: return 8'h00;
    endcase
  endfunction : rreg

  task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d, input logic cl = 1'b0,
                    input logic [7:0] cp = 8'h00, input int gap = 0);
    int          t;
    logic [21:0] x;
    logic [7:0]  r;
    t = tgt(a);
    x = ext(a, t);
    r = rreg(a[9:0]);
    pmwd_core_model_i.access(w, a, d, cl, cp, gap);
    `CHK("valid", 1'b1, target_valid_q)
    `CHK("target", 4'(t), target_q)
    `CHK("ext", x, ext_addr_q)
    `CHK("local", a, local_addr_q)
    if (t == 1 && !w) `CHK("rdata", r, reg_rdata_q)
    if (t == 1 && w) begin
      case (a[9:0])
        10'h030: pp = d;
        10'h031: dp = d;
        10'h032: ep = d;
        10'h033: en = d[2:0];
        10'h034: db = d;
        10'h035: ds = d[1:0];
        10'h036: xb = d;
        10'h037: xs = d[1:0];
        10'h038: rb = d[7:2];
        default: ;
      endcase
    end
    if (cl) pp = cp;
    `CHK("pages", {pp[7:0], dp[7:0], ep[7:0]}, {program_page_select, data_page_select, extra_page_select})
  endtask : op

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    background_debug_active = 1'b0;
    pp = 0;
    dp = 0;
    ep = 0;
    en = 0;
    rb = 0;
    dbg = 0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    op(1'b0, 16'hfffe, 8'h00);
    op(1'b0, 16'h9000, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      op(1'b1, 16'h0030 + 16'(i), rnd[7:0]);
    end
    op(1'b1, 16'h0033, 8'h07);
    op(1'b1, 16'h003c, 8'h5a);
    for (int k = 0; k < 2; k++) begin
      foreach (addrs[i]) op(1'b0, addrs[i], 8'h00);
      dbg = 1;
      background_debug_active = 1'b1;
    end
    dbg = 0;
    background_debug_active = 1'b0;
    rnd = lfsr(rnd);
    op(1'b1, 16'h0030, 8'h11, 1'b1, rnd[7:0]);
    op(1'b0, 16'hbffe, 8'h00);
    op(1'b1, 16'h0038, 8'h04);
    op(1'b0, 16'h0431, 8'h00);
    op(1'b0, 16'h0500, 8'h00);
    op(1'b0, 16'h0030, 8'h00);
    op(1'b1, 16'h0434, 8'h20);
    op(1'b1, 16'h0435, 8'h01);
    op(1'b1, 16'h0437, 8'h02);
    op(1'b0, 16'h3abc, 8'h00);
    op(1'b0, 16'h0123, 8'h00);
    op(1'b0, 16'h0435, 8'h00);
    repeat (60) begin
      rnd = lfsr(rnd);
      dbg = int'(rnd[16]);
      background_debug_active = rnd[16];
      op(1'b0, rnd[15:0], 8'h00, rnd[17], rnd[31:24], int'(rnd[19:18]));
    end
    give_verdict();
  end
endmodule : pmwd_decoder_tb
